// ### src/fpg_pkg.sv
// Package with register offsets, field layouts and bus codes of the fast GPIO port.
package fpg_pkg;

  // ==========================================================================
  // Register space
  // ==========================================================================
  localparam int         PORT_WIDTH        = 16;
  localparam int         SLOT_COUNT        = 8;
  localparam logic [3:0] OFS_PORT_WAY      = 4'h0;
  localparam logic [3:0] OFS_PORT_VALUE    = 4'h2;
  localparam logic [3:0] OFS_PORT_CLAIM    = 4'h4;
  localparam logic [3:0] OFS_PORT_ZERO     = 4'h6;
  localparam logic [3:0] OFS_HOLE_LOW      = 4'h8;
  localparam logic [3:0] OFS_PORT_ONE      = 4'hA;
  localparam logic [3:0] OFS_HOLE_HIGH     = 4'hC;
  localparam logic [3:0] OFS_PORT_FLIP     = 4'hE;

  // ==========================================================================
  // Word slots, one for each two-byte field
  // ==========================================================================
  localparam logic [2:0] SLOT_WAY          = 3'h0;
  localparam logic [2:0] SLOT_VALUE        = 3'h1;
  localparam logic [2:0] SLOT_CLAIM        = 3'h2;
  localparam logic [2:0] SLOT_ZERO         = 3'h3;
  localparam logic [2:0] SLOT_HOLE_LOW     = 3'h4;
  localparam logic [2:0] SLOT_ONE          = 3'h5;
  localparam logic [2:0] SLOT_HOLE_HIGH    = 3'h6;
  localparam logic [2:0] SLOT_FLIP         = 3'h7;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [15:0] RST_PORT_WAY     = 16'h0000;
  localparam logic [15:0] RST_PORT_VALUE   = 16'h0000;
  localparam logic [15:0] RST_PORT_CLAIM   = 16'h0000;
  localparam logic [31:0] RST_READ_DATA    = 32'h0000_0000;

  // ==========================================================================
  // Access sizes on the local bus
  // ==========================================================================
  localparam logic [1:0] SIZE_BYTE         = 2'h0;
  localparam logic [1:0] SIZE_WORD         = 2'h1;
  localparam logic [1:0] SIZE_LONG         = 2'h2;

  typedef enum logic [1:0] {FPG_IDLE, FPG_READ, FPG_WRITE} fpg_phase_t;

endpackage

// ### src/fpg_pin_sync.sv
// Three-stage synchroniser for the port pin inputs.
`timescale 1ns/10ps

module fpg_pin_sync
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic [15:0] pin_in,
  output logic      [15:0] level
);

  logic [15:0] meta_reg;
  logic [15:0] mid_reg;
  logic [15:0] late_reg;
  logic [15:0] level_reg;
  logic [15:0] level_next;

  // ==========================================================================
  // Filter
  // ==========================================================================
  // A bit only takes a new level once the second and third stages agree.
  always_comb
  begin
    level_next = level_reg;
    for (int i = 0; i < 16; i++)
    begin
      if (mid_reg[i] == late_reg[i])
      begin
        level_next[i] = late_reg[i];
      end
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      meta_reg  <= 16'h0000;
      mid_reg   <= 16'h0000;
      late_reg  <= 16'h0000;
      level_reg <= 16'h0000;
    end
    else
    begin
      meta_reg  <= pin_in;
      mid_reg   <= meta_reg;
      late_reg  <= mid_reg;
      level_reg <= level_next;
    end
  end

  assign level = level_reg;

endmodule

// ### src/fpg_lane_reg.sv
// Sixteen-bit register with two byte-lane write strobes and synchronous clear.
`timescale 1ns/10ps

module fpg_lane_reg
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        wr_en,
  input  wire logic [1:0]  lane_mask,
  input  wire logic [15:0] wr_data,
  output logic      [15:0] q
);

  logic [15:0] q_reg;
  logic [15:0] q_next;
  logic [15:0] bit_mask;

  // ==========================================================================
  // Byte-lane merge
  // ==========================================================================
  always_comb
  begin
    bit_mask = {{8{lane_mask[1]}}, {8{lane_mask[0]}}};
    q_next   = q_reg;
    if (wr_en)
    begin
      q_next = (q_reg & ~bit_mask) | (wr_data & bit_mask);
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      q_reg <= 16'h0000;
    end
    else
    begin
      q_reg <= q_next;
    end
  end

  assign q = q_reg;

endmodule

// ### src/fpg_port.sv
// Fast sixteen-bit GPIO port on the processor's two-stage pipelined local bus.
`timescale 1ns/10ps

// Functional notes
// R1 - Enabled pin: direction one drives, zero listens.
// R2 - Reset clears direction and data registers.
// R3 - Enabled output pin drives its data bit.
// R4 - Data read returns sampled enabled input levels.
// R5 - Disabled pin read data is undefined.
// R6 - Enable bit routes pin to this port.
// R7 - Reset clears all enables, port disabled.
// R8 - Clear alias: written zeros clear data.
// R9 - Set alias: written ones set data.
// R10 - Invert alias: written ones flip data.
// R11 - Alias reads return the data register.
// R12 - Every access completes without wait states.
// R13 - Software enables, sets direction, then data.
// R14 - Inputs sampled at read data-phase edge.
// R15 - Outputs change at write data-phase edge.
// R16 - Decode fixed offsets; holes alter nothing.
// R17 - Byte, word, longword; no mode check.
// R18 - Byte writes touch only their lane.
// R19 - Direct and alias writes share edge.
module fpg_port
(
  input  wire logic        clock,
  input  wire logic        srst,
  input  wire logic        bus_addr_valid,
  input  wire logic [3:0]  bus_addr,
  input  wire logic        bus_write,
  input  wire logic [1:0]  bus_size,
  input  wire logic [31:0] bus_wdata,
  output logic      [31:0] bus_rdata,
  output logic             bus_done,
  input  wire logic [15:0] pin_in,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe,
  output logic      [15:0] pin_claim
);

  // ==========================================================================
  // Decoding helpers
  // ==========================================================================
  // Byte enables on the big-endian lanes: offset 0 is bits 31..24.
  function automatic logic [3:0] lane_enables(input logic [1:0] size, input logic [1:0] ofs);
    logic [3:0] be;
    be = 4'h0;
    case (size)
      fpg_pkg::SIZE_BYTE: be = 4'h8 >> ofs;
      fpg_pkg::SIZE_WORD: be = ofs[1] ? 4'h3 : 4'hC;
      default:            be = 4'hF;
    endcase
    return be;
  endfunction

  function automatic logic [15:0] lane_bits(input logic [1:0] mask);
    return {{8{mask[1]}}, {8{mask[0]}}};
  endfunction

  // ==========================================================================
  // Pipeline phase
  // ==========================================================================
  fpg_pkg::fpg_phase_t phase_reg;
  fpg_pkg::fpg_phase_t phase_next;
  logic [3:0]          addr_reg;
  logic [3:0]          addr_next;
  logic [1:0]          size_reg;
  logic [1:0]          size_next;
  logic                done_reg;
  logic                done_next;

  // R12 - single data phase
  always_comb
  begin
    phase_next = fpg_pkg::FPG_IDLE;
    addr_next  = addr_reg;
    size_next  = size_reg;
    done_next  = 1'b0;
    if (bus_addr_valid)
    begin
      phase_next = bus_write ? fpg_pkg::FPG_WRITE : fpg_pkg::FPG_READ;
      addr_next  = bus_addr;
      size_next  = bus_size;
      done_next  = 1'b1;
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      phase_reg <= fpg_pkg::FPG_IDLE;
      addr_reg  <= 4'h0;
      size_reg  <= fpg_pkg::SIZE_LONG;
      done_reg  <= 1'b0;
    end
    else
    begin
      phase_reg <= phase_next;
      addr_reg  <= addr_next;
      size_reg  <= size_next;
      done_reg  <= done_next;
    end
  end

  // ==========================================================================
  // Write decode per two-byte slot
  // ==========================================================================
  logic [3:0]  wr_be;
  logic [7:0]  slot_hit;
  logic [1:0]  slot_mask [8];
  logic [15:0] slot_data [8];

  assign wr_be = lane_enables(size_reg, addr_reg[1:0]);

  // R17 - any size
  genvar gs;
  generate
    for (gs = 0; gs < fpg_pkg::SLOT_COUNT; gs++)
    begin : g_slot
      localparam logic [2:0] SLOT = 3'(gs);
      assign slot_mask[gs] = SLOT[0] ? wr_be[1:0] : wr_be[3:2];
      assign slot_data[gs] = SLOT[0] ? bus_wdata[15:0] : bus_wdata[31:16];
      assign slot_hit[gs]  = (phase_reg == fpg_pkg::FPG_WRITE) &&
                             (addr_reg[3:2] == SLOT[2:1]) && (|slot_mask[gs]);
    end
  endgenerate

  // ==========================================================================
  // Direction and enable registers
  // ==========================================================================
  logic [15:0] way_q;
  logic [15:0] claim_q;

  // R2 - direction cleared
  fpg_lane_reg u_way
  (
    .clock     (clock),
    .srst      (srst),
    .wr_en     (slot_hit[fpg_pkg::SLOT_WAY]),
    .lane_mask (slot_mask[fpg_pkg::SLOT_WAY]),
    .wr_data   (slot_data[fpg_pkg::SLOT_WAY]),
    .q         (way_q)
  );

  // R7 - enables cleared
  fpg_lane_reg u_claim
  (
    .clock     (clock),
    .srst      (srst),
    .wr_en     (slot_hit[fpg_pkg::SLOT_CLAIM]),
    .lane_mask (slot_mask[fpg_pkg::SLOT_CLAIM]),
    .wr_data   (slot_data[fpg_pkg::SLOT_CLAIM]),
    .q         (claim_q)
  );

  // ==========================================================================
  // Output data register and its aliases
  // ==========================================================================
  logic [15:0] value_reg;
  logic [15:0] value_next;
  logic [15:0] way_next;
  logic [15:0] claim_next;
  logic [15:0] out_reg;
  logic [15:0] oe_reg;
  logic [15:0] claim_out_reg;

  // R16 - holes alter nothing
  always_comb
  begin
    value_next = value_reg;
    // R18 - lane-limited merge
    if (slot_hit[fpg_pkg::SLOT_VALUE])
    begin
      value_next = (value_next & ~lane_bits(slot_mask[fpg_pkg::SLOT_VALUE])) |
                   (slot_data[fpg_pkg::SLOT_VALUE] & lane_bits(slot_mask[fpg_pkg::SLOT_VALUE]));
    end
    // R8 - clear on zeros
    if (slot_hit[fpg_pkg::SLOT_ZERO])
    begin
      value_next = value_next & (slot_data[fpg_pkg::SLOT_ZERO] |
                                 ~lane_bits(slot_mask[fpg_pkg::SLOT_ZERO]));
    end
    // R9 - set on ones
    if (slot_hit[fpg_pkg::SLOT_ONE])
    begin
      value_next = value_next | (slot_data[fpg_pkg::SLOT_ONE] &
                                 lane_bits(slot_mask[fpg_pkg::SLOT_ONE]));
    end
    // R10 - invert on ones
    if (slot_hit[fpg_pkg::SLOT_FLIP])
    begin
      value_next = value_next ^ (slot_data[fpg_pkg::SLOT_FLIP] &
                                 lane_bits(slot_mask[fpg_pkg::SLOT_FLIP]));
    end
  end

  // Pin registers are loaded from the same next values as the control registers.
  always_comb
  begin
    way_next = way_q;
    if (slot_hit[fpg_pkg::SLOT_WAY])
    begin
      way_next = (way_q & ~lane_bits(slot_mask[fpg_pkg::SLOT_WAY])) |
                 (slot_data[fpg_pkg::SLOT_WAY] & lane_bits(slot_mask[fpg_pkg::SLOT_WAY]));
    end
    claim_next = claim_q;
    if (slot_hit[fpg_pkg::SLOT_CLAIM])
    begin
      claim_next = (claim_q & ~lane_bits(slot_mask[fpg_pkg::SLOT_CLAIM])) |
                   (slot_data[fpg_pkg::SLOT_CLAIM] & lane_bits(slot_mask[fpg_pkg::SLOT_CLAIM]));
    end
  end

  // R15 - change at write edge
  // R19 - one edge for all
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      value_reg     <= fpg_pkg::RST_PORT_VALUE;
      out_reg       <= fpg_pkg::RST_PORT_VALUE;
      oe_reg        <= fpg_pkg::RST_PORT_WAY;
      claim_out_reg <= fpg_pkg::RST_PORT_CLAIM;
    end
    else
    begin
      value_reg     <= value_next;
      out_reg       <= value_next;
      oe_reg        <= way_next & claim_next;
      claim_out_reg <= claim_next;
    end
  end

  // ==========================================================================
  // Read path
  // ==========================================================================
  logic [15:0] pin_level;
  logic [15:0] value_view;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  fpg_pin_sync u_sync
  (
    .clock  (clock),
    .srst   (srst),
    .pin_in (pin_in),
    .level  (pin_level)
  );

  // R4 - enabled inputs read the pin
  // R5 - disabled pins show the stored bit
  assign value_view = (claim_q & ~way_q & pin_level) | (~(claim_q & ~way_q) & value_reg);

  function automatic logic [15:0] slot_read(input logic [2:0] slot, input logic [15:0] way,
                                            input logic [15:0] view, input logic [15:0] claim);
    logic [15:0] w;
    w = way;
    case (slot)
      fpg_pkg::SLOT_VALUE: w = view;
      fpg_pkg::SLOT_CLAIM: w = claim;
      // R11 - alias reads data
      fpg_pkg::SLOT_ZERO:  w = view;
      fpg_pkg::SLOT_ONE:   w = view;
      fpg_pkg::SLOT_FLIP:  w = view;
      default:             w = way;
    endcase
    return w;
  endfunction

  // R14 - sample at read edge
  always_comb
  begin
    rdata_next = rdata_reg;
    if (bus_addr_valid && !bus_write)
    begin
      rdata_next = {slot_read({bus_addr[3:2], 1'b0}, way_q, value_view, claim_q),
                    slot_read({bus_addr[3:2], 1'b1}, way_q, value_view, claim_q)};
    end
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      rdata_reg <= fpg_pkg::RST_READ_DATA;
    end
    else
    begin
      rdata_reg <= rdata_next;
    end
  end

  // R1 - direction with enable
  // R3 - drive data bit
  // R6 - routed pins
  assign pin_oe    = oe_reg;
  assign pin_out   = out_reg;
  assign pin_claim = claim_out_reg;
  assign bus_rdata = rdata_reg;
  assign bus_done  = done_reg;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  sequence s_word_write(logic [3:0] ofs);
    phase_reg == fpg_pkg::FPG_WRITE && addr_reg == ofs && size_reg == fpg_pkg::SIZE_WORD;
  endsequence
  sequence s_read_at(logic [3:0] ofs);
    bus_addr_valid && !bus_write && bus_addr == ofs;
  endsequence

  a_reset_clear: assert property (disable iff (1'b0) srst |=> // R2 R7
    {pin_out, pin_oe, pin_claim} == 48'h0000_0000_0000) else $error("reset left pins set");
  a_oe_follow: assert property (pin_oe == (way_q & claim_q)) // R1
    else $error("output enable mismatch");
  a_out_follow: assert property (pin_out == value_reg) // R3
    else $error("pin out mismatch");
  a_claim_follow: assert property (pin_claim == claim_q) // R6
    else $error("claim mismatch");
  a_clear_alias: assert property (s_word_write(fpg_pkg::OFS_PORT_ZERO) |=> // R8
    value_reg == ($past(value_reg) & $past(bus_wdata[15:0]))) else $error("clear alias wrong");
  a_set_alias: assert property (s_word_write(fpg_pkg::OFS_PORT_ONE) |=> // R9
    value_reg == ($past(value_reg) | $past(bus_wdata[15:0]))) else $error("set alias wrong");
  a_flip_alias: assert property (s_word_write(fpg_pkg::OFS_PORT_FLIP) |=> // R10
    value_reg == ($past(value_reg) ^ $past(bus_wdata[15:0]))) else $error("invert alias wrong");
  a_alias_read: assert property ((s_read_at(fpg_pkg::OFS_PORT_ONE) or // R11
    s_read_at(fpg_pkg::OFS_PORT_FLIP)) |=> bus_rdata[15:0] == $past(value_view))
    else $error("alias read wrong");
  a_one_phase: assert property (bus_addr_valid |=> // R12
    bus_done ##0 (bus_addr_valid or ##1 !bus_done)) else $error("data phase not single");
  a_hole_quiet: assert property (s_word_write(fpg_pkg::OFS_HOLE_LOW) |=> // R16
    $stable(value_reg) && $stable(way_q) && $stable(claim_q)) else $error("hole write had effect");
  a_byte_lane: assert property (phase_reg == fpg_pkg::FPG_WRITE && // R18
    addr_reg == fpg_pkg::OFS_PORT_VALUE && size_reg == fpg_pkg::SIZE_BYTE |=>
    value_reg[7:0] == $past(value_reg[7:0])) else $error("byte write leaked");

endmodule

// ### bench/fpg_core_model.sv
// Processor-side master model for the fast port's pipelined local bus.
`timescale 1ns/10ps

module fpg_core_model
(
  input  wire logic        clock,
  output logic             bus_addr_valid,
  output logic [3:0]       bus_addr,
  output logic             bus_write,
  output logic [1:0]       bus_size,
  output logic [31:0]      bus_wdata,
  input  wire logic [31:0] bus_rdata,
  input  wire logic        bus_done
);
  initial
  begin
    bus_addr_valid = 1'b0;
    bus_addr       = 4'h5;
    bus_write      = 1'b0;
    bus_size       = 2'h3;
    bus_wdata      = 32'hA5C3_5A3C;
  end

  // one address phase, then a data phase answered with no wait.
  task automatic xfer(input logic wr, input logic [3:0] addr, input logic [1:0] size,
                      input logic [31:0] wdata, output logic [31:0] rdata,
                      output logic done);
    @(negedge clock);
    bus_addr_valid = 1'b1;
    bus_addr       = addr;
    bus_write      = wr;
    bus_size       = size;
    @(negedge clock);
    bus_addr_valid = 1'b0;
    bus_addr       = ~addr;
    bus_write      = ~wr;
    bus_size       = ~size;
    bus_wdata      = wr ? wdata : ~bus_wdata;
    rdata          = bus_rdata;
    done           = bus_done;
  endtask
endmodule

// ### bench/testbench.sv
// Self-checking testbench for the fast GPIO port.
`timescale 1ns/10ps

module testbench;
  logic        clock;
  logic        srst;
  logic [15:0] pin_in;
  logic        bus_addr_valid;
  logic [3:0]  bus_addr;
  logic        bus_write;
  logic [1:0]  bus_size;
  logic [31:0] bus_wdata;
  logic [31:0] bus_rdata;
  logic        bus_done;
  logic [15:0] pin_out;
  logic [15:0] pin_oe;
  logic [15:0] pin_claim;
  logic [15:0] m_dir;
  logic [15:0] m_data;
  logic [15:0] m_enb;
  logic [15:0] m_pin;
  int          err_count;
  int          tests_run;
  int          cycles;

  fpg_port dut_u (.clock(clock), .srst(srst), .bus_addr_valid(bus_addr_valid),
    .bus_addr(bus_addr), .bus_write(bus_write), .bus_size(bus_size),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_done(bus_done),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_claim(pin_claim));

  fpg_core_model core_u (.clock(clock), .bus_addr_valid(bus_addr_valid),
    .bus_addr(bus_addr), .bus_write(bus_write), .bus_size(bus_size),
    .bus_wdata(bus_wdata), .bus_rdata(bus_rdata), .bus_done(bus_done));

  always #5 clock = ~clock;

  // ==========================================================================
  // Checking and expectation helpers
  // ==========================================================================
  task automatic finish_test;
    if (err_count == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      err_count++;
    end
  endtask

  // In data and alias slots, enabled input pins show the pin level, all other bits the stored data.
  function automatic logic [15:0] view(input logic [2:0] slot);
    case (slot)
      3'h2: view = m_enb;
      3'h0, 3'h4, 3'h6: view = m_dir;
      default: view = (m_data & ~(m_enb & ~m_dir)) | (m_pin & m_enb & ~m_dir);
    endcase
  endfunction

  task automatic apply(input logic [2:0] slot, input logic [15:0] lm, input logic [15:0] v);
    case (slot)
      3'h0: m_dir = (m_dir & ~lm) | (v & lm);
      3'h1: m_data = (m_data & ~lm) | (v & lm);
      3'h2: m_enb = (m_enb & ~lm) | (v & lm);
      3'h3: m_data = m_data & ~(~v & lm);
      3'h5: m_data = m_data | (v & lm);
      3'h7: m_data = m_data ^ (v & lm);
      default: ;
    endcase
  endtask

  task automatic check_pins;
    check("pin_out", {16'h0, pin_out}, {16'h0, m_data});
    check("pin_oe", {16'h0, pin_oe}, {16'h0, m_dir & m_enb});
    check("pin_claim", {16'h0, pin_claim}, {16'h0, m_enb});
  endtask

  task automatic access(input logic wr, input logic [3:0] a, input logic [1:0] sz,
                        input logic [31:0] v);
    logic [31:0] rd;
    logic        dn;
    core_u.xfer(wr, a, sz, v, rd, dn);
    check("bus_done", {31'h0, dn}, 32'h1);
    if (wr)
    begin
      if (sz == fpg_pkg::SIZE_BYTE)
        apply(a[3:1], a[0] ? 16'h00FF : 16'hFF00, v[15:0]);
      else if (sz == fpg_pkg::SIZE_WORD)
        apply(a[3:1], 16'hFFFF, v[15:0]);
      else
      begin
        apply({a[3:2], 1'b0}, 16'hFFFF, v[31:16]);
        apply({a[3:2], 1'b1}, 16'hFFFF, v[15:0]);
      end
      @(negedge clock);
      check_pins();
    end
    else
      check("bus_rdata", rd, {view({a[3:2], 1'b0}), view({a[3:2], 1'b1})});
  endtask

  task automatic read_all;
    for (int k = 0; k < 16; k += 4)
      access(1'b0, 4'(k), fpg_pkg::SIZE_LONG, 32'h0);
  endtask

  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial
  begin
    logic [1:0]  sz;
    logic [3:0]  a;
    logic [31:0] v;
    clock     = 1'b0;
    srst      = 1'b1;
    pin_in    = 16'h0000;
    m_dir     = 16'h0000;
    m_data    = 16'h0000;
    m_enb     = 16'h0000;
    m_pin     = 16'h0000;
    err_count = 0;
    tests_run = 0;
    cycles    = 0;
    void'($urandom(5140));
    repeat (20) @(negedge clock);
    srst = 1'b0;
    check_pins();
    read_all();
    access(1'b1, fpg_pkg::OFS_PORT_CLAIM, fpg_pkg::SIZE_WORD, {2{16'hFFFF}});
    access(1'b1, fpg_pkg::OFS_PORT_WAY, fpg_pkg::SIZE_WORD, {2{16'h00FF}});
    access(1'b1, fpg_pkg::OFS_PORT_VALUE, fpg_pkg::SIZE_WORD, {2{16'h0F0F}});
    pin_in = 16'hC3A5;
    m_pin  = pin_in;
    repeat (6) @(negedge clock);
    read_all();
    access(1'b1, fpg_pkg::OFS_PORT_ZERO, fpg_pkg::SIZE_WORD, {2{16'hF0F0}});
    access(1'b1, fpg_pkg::OFS_PORT_ONE, fpg_pkg::SIZE_WORD, {2{16'h00F3}});
    access(1'b1, fpg_pkg::OFS_PORT_FLIP, fpg_pkg::SIZE_WORD, {2{16'hFF0F}});
    access(1'b1, fpg_pkg::OFS_HOLE_LOW, fpg_pkg::SIZE_WORD, {2{16'hFFFF}});
    access(1'b1, fpg_pkg::OFS_HOLE_HIGH, fpg_pkg::SIZE_LONG, 32'hFFFF_0001);
    read_all();
    for (int i = 0; i < 300; i++)
    begin
      if (i % 25 == 0)
      begin
        pin_in = 16'($urandom());
        m_pin  = pin_in;
        repeat (6) @(negedge clock);
      end
      sz = 2'($urandom_range(2, 0));
      a  = 4'($urandom());
      v  = $urandom();
      if (sz == fpg_pkg::SIZE_BYTE)
        v = {4{v[7:0]}};
      else if (sz == fpg_pkg::SIZE_WORD)
      begin
        a = a & 4'hE;
        v = {2{v[15:0]}};
      end
      else
        a = a & 4'hC;
      access(1'(($urandom() >> 3) & 1), a, sz, v);
    end
    srst = 1'b1;
    repeat (2) @(negedge clock);
    m_dir  = 16'h0000;
    m_data = 16'h0000;
    m_enb  = 16'h0000;
    check_pins();
    check("bus_done", {31'h0, bus_done}, 32'h0);
    srst = 1'b0;
    read_all();
    finish_test();
  end
endmodule
